// File: inc/acmtc_pkg.sv
// Constants and types for the converter mode, test and clock register bank
package acmtc_pkg;
    // ======================================================
    // Register offsets
    localparam logic [7:0] A_CHSEL = 8'h05;
    localparam logic [7:0] A_MODES = 8'h08;
    localparam logic [7:0] A_CLKCFG = 8'h09;
    localparam logic [7:0] A_CLKDIV = 8'h0B;
    localparam logic [7:0] A_TEST = 8'h0D;
    localparam logic [7:0] A_SELF_TEST = 8'h0E;
    localparam logic [7:0] A_COMMIT = 8'hFF;
    // ======================================================
    // Reset values
    localparam logic [7:0] R_CHSEL = 8'h03;
    localparam logic [7:0] R_MODES = 8'h80;
    localparam logic [7:0] R_ZERO = 8'h00;
    // ======================================================
    // Field positions
    localparam int COMMIT_BIT = 0;
    localparam int SEL_A_BIT = 0;
    localparam int SEL_B_BIT = 1;
    localparam int DCS_BIT = 0;
    localparam int SELF_TEST_EN_BIT = 0;
    localparam int SELF_TEST_INIT_BIT = 2;
    localparam int PN_LONG_RST_BIT = 5;
    localparam int PN_SHORT_RST_BIT = 4;
    localparam logic [2:0] DIV_MAX = 3'h5;
    // ======================================================
    // Operating modes and test pattern codes
    typedef enum logic [1:0] {
        MD_RUN = 2'h0, MD_PWRDN = 2'h1, MD_STBY = 2'h2, MD_DRST = 2'h3
    } acmtc_mode_e;
    typedef enum logic [3:0] {
        TM_OFF = 4'h0, TM_MID = 4'h1, TM_POS = 4'h2, TM_NEG = 4'h3,
        TM_CHECK = 4'h4, TM_PNL = 4'h5, TM_PNS = 4'h6, TM_WORD = 4'h7,
        TM_USER = 4'h8, TM_BIT = 4'h9, TM_SYNC = 4'hA, TM_ONE = 4'hB,
        TM_MIX = 4'hC
    } acmtc_test_e;
    // ======================================================
    // Pattern values and generator seeds
    localparam int DW = 16;
    localparam logic [15:0] P_MID = 16'h8000;
    localparam logic [15:0] P_POS = 16'hFFFF;
    localparam logic [15:0] P_NEG = 16'h0000;
    localparam logic [15:0] P_CHK_A = 16'hAAAA;
    localparam logic [15:0] P_CHK_B = 16'h5555;
    localparam logic [15:0] P_SYNC = 16'h00FF;
    localparam logic [15:0] P_MIX_A = 16'hF0CC;
    localparam logic [15:0] P_MIX_B = 16'h0F33;
    localparam logic [15:0] P_WALK = 16'h0001;
    localparam logic [22:0] PNL_SEED = 23'h7F_FFFF;
    localparam logic [8:0] PNS_SEED = 9'h1FF;
    // ======================================================
    // Per-channel and global settings
    typedef struct packed {
        logic [7:0] modes;
        logic [7:0] test;
    } acmtc_chan_s;
    typedef struct packed {
        logic [7:0] clkcfg;
        logic [7:0] clkdiv;
        logic [7:0] self_test;
    } acmtc_glob_s;
endpackage : acmtc_pkg

// File: rtl/acmtc_regs.sv
// Mode, clock divider, test pattern and self-test register bank
`timescale 1ns/1ps
module acmtc_regs
    import acmtc_pkg::*;
#(
    parameter logic [15:0] USER_PATTERN = 16'h0000
) (
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    input wire logic I_CE,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    output logic [7:0] O_REG_RDATA,
    output logic O_REG_RVALID,
    input wire logic [DW-1:0] I_SAMPLE_A,
    input wire logic [DW-1:0] I_SAMPLE_B,
    output logic O_SAMPLE_STROBE,
    output logic [DW-1:0] O_DATA_A,
    output logic [DW-1:0] O_DATA_B,
    output logic [1:0] O_PWRDN,
    output logic [1:0] O_STANDBY,
    output logic O_DIG_RESET,
    output logic O_DCS_EN,
    output logic O_SELF_TEST_EN,
    output logic O_SELF_TEST_INIT
);
    // ======================================================
    // Register file
    acmtc_chan_s shd_ff [2];
    acmtc_chan_s act_ff [2];
    acmtc_chan_s nxt_shd [2];
    acmtc_chan_s nxt_act [2];
    acmtc_glob_s gshd_ff, gact_ff, nxt_gshd, nxt_gact;
    logic [7:0] sel_ff, nxt_sel, rdata_ff, nxt_rdata;
    logic commit_ff, nxt_commit, rvalid_ff, nxt_rvalid;
    logic local_hit;

    // Mode, test, clock and self-test writes land in the shadow copy; the active copy only moves on commit
    always_comb begin
        nxt_shd = shd_ff;
        nxt_act = act_ff;
        nxt_gshd = gshd_ff;
        nxt_gact = gact_ff;
        nxt_sel = sel_ff;
        nxt_commit = commit_ff;
        nxt_rdata = rdata_ff;
        nxt_rvalid = 1'b0;
        local_hit = (I_REG_ADDR == A_MODES) || (I_REG_ADDR == A_TEST);
        if (commit_ff) begin
            nxt_act = shd_ff;
            nxt_gact = gshd_ff;
            nxt_commit = 1'b0;
        end
        if (I_REG_WR) begin
            for (int c = 0; c < 2; c++) begin
                if (sel_ff[c]) begin
                    if (I_REG_ADDR == A_MODES) nxt_shd[c].modes = I_REG_WDATA;
                    if (I_REG_ADDR == A_TEST) nxt_shd[c].test = I_REG_WDATA;
                end
            end
            case (I_REG_ADDR)
                A_CHSEL: nxt_sel = I_REG_WDATA & R_CHSEL;
                A_CLKCFG: nxt_gshd.clkcfg = I_REG_WDATA;
                A_CLKDIV: nxt_gshd.clkdiv = I_REG_WDATA;
                A_SELF_TEST: nxt_gshd.self_test = I_REG_WDATA;
                // A new commit in the clearing cycle wins over the clear
                A_COMMIT: if (I_REG_WDATA[COMMIT_BIT]) nxt_commit = 1'b1;
                default: ;
            endcase
        end
        if (I_REG_RD) begin
            nxt_rvalid = 1'b1;
            case (I_REG_ADDR)
                A_CHSEL: nxt_rdata = sel_ff;
                // Channel A answers whenever its select bit is set, otherwise channel B
                A_MODES: nxt_rdata = sel_ff[SEL_A_BIT] ? shd_ff[0].modes
                                                       : shd_ff[1].modes;
                A_TEST: nxt_rdata = sel_ff[SEL_A_BIT] ? shd_ff[0].test
                                                      : shd_ff[1].test;
                A_CLKCFG: nxt_rdata = gshd_ff.clkcfg;
                A_CLKDIV: nxt_rdata = gshd_ff.clkdiv;
                A_SELF_TEST: nxt_rdata = gshd_ff.self_test;
                A_COMMIT: nxt_rdata = {7'h00, commit_ff};
                default: nxt_rdata = R_ZERO;
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            for (int c = 0; c < 2; c++) begin
                shd_ff[c] <= '{modes: R_MODES, test: R_ZERO};
                act_ff[c] <= '{modes: R_MODES, test: R_ZERO};
            end
            gshd_ff <= '{clkcfg: R_ZERO, clkdiv: R_ZERO, self_test: R_ZERO};
            gact_ff <= '{clkcfg: R_ZERO, clkdiv: R_ZERO, self_test: R_ZERO};
            sel_ff <= R_CHSEL;
            commit_ff <= 1'b0;
            rdata_ff <= R_ZERO;
            rvalid_ff <= 1'b0;
        end else if (I_CE) begin
            shd_ff <= nxt_shd;
            act_ff <= nxt_act;
            gshd_ff <= nxt_gshd;
            gact_ff <= nxt_gact;
            sel_ff <= nxt_sel;
            commit_ff <= nxt_commit;
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // ======================================================
    // Clock divider and pattern generators
    logic [2:0] div_eff, cnt_ff, nxt_cnt;
    logic hit, strobe_ff, nxt_strobe;
    logic [22:0] pnl_ff [2];
    logic [22:0] nxt_pnl [2];
    logic [8:0] pns_ff [2];
    logic [8:0] nxt_pns [2];
    logic [DW-1:0] walk_ff [2];
    logic [DW-1:0] nxt_walk [2];
    logic [DW-1:0] data_ff [2];
    logic [DW-1:0] nxt_data [2];
    logic [1:0] tog_ff, nxt_tog, pd_ff, nxt_pd, sb_ff, nxt_sb;
    logic drst_ff, nxt_drst;
    logic [DW-1:0] smp [2];

    // Pattern selection shared by both channels
    function automatic logic [DW-1:0] pat_sel(input logic [3:0] code, input logic tog,
            input logic [22:0] pnl, input logic [8:0] pns, input logic [DW-1:0] walk,
            input logic [DW-1:0] s);
        case (code)
            TM_OFF: pat_sel = s;
            TM_MID: pat_sel = P_MID;
            TM_POS: pat_sel = P_POS;
            TM_NEG: pat_sel = P_NEG;
            TM_CHECK: pat_sel = tog ? P_CHK_B : P_CHK_A;
            TM_PNL: pat_sel = pnl[DW-1:0];
            TM_PNS: pat_sel = {{(DW-9){1'b0}}, pns};
            TM_WORD: pat_sel = tog ? P_POS : P_NEG;
            TM_USER: pat_sel = USER_PATTERN;
            TM_BIT: pat_sel = tog ? P_CHK_A : P_NEG;
            TM_SYNC: pat_sel = P_SYNC;
            TM_ONE: pat_sel = walk;
            TM_MIX: pat_sel = tog ? P_MIX_B : P_MIX_A;
            default: pat_sel = s;
        endcase
    endfunction : pat_sel

    // Codes above divide-by-six are clamped so the counter cannot stall
    assign div_eff = (gact_ff.clkdiv[2:0] > DIV_MAX) ? DIV_MAX : gact_ff.clkdiv[2:0];
    // A count left above a newly lowered ratio wraps at once instead of running to 7
    assign hit = (cnt_ff >= div_eff);
    assign smp[0] = I_SAMPLE_A;
    assign smp[1] = I_SAMPLE_B;

    // Generators and output data step once per divided sample clock
    always_comb begin
        nxt_cnt = hit ? 3'h0 : cnt_ff + 3'h1;
        nxt_strobe = hit;
        nxt_pnl = pnl_ff;
        nxt_pns = pns_ff;
        nxt_walk = walk_ff;
        nxt_tog = tog_ff;
        nxt_data = data_ff;
        nxt_drst = 1'b0;
        for (int c = 0; c < 2; c++) begin
            nxt_pd[c] = (act_ff[c].modes[1:0] == MD_PWRDN);
            nxt_sb[c] = (act_ff[c].modes[1:0] == MD_STBY);
            if (act_ff[c].modes[1:0] == MD_DRST) nxt_drst = 1'b1;
            if (hit) begin
                nxt_data[c] = pat_sel(act_ff[c].test[3:0], tog_ff[c], pnl_ff[c],
                                      pns_ff[c], walk_ff[c], smp[c]);
                nxt_pnl[c] = {pnl_ff[c][21:0], pnl_ff[c][22] ^ pnl_ff[c][17]};
                nxt_pns[c] = {pns_ff[c][7:0], pns_ff[c][8] ^ pns_ff[c][4]};
                nxt_walk[c] = {walk_ff[c][DW-2:0], walk_ff[c][DW-1]};
                nxt_tog[c] = ~tog_ff[c];
            end
            // Held reset bits park the generators at their seeds
            if (act_ff[c].test[PN_LONG_RST_BIT]) nxt_pnl[c] = PNL_SEED;
            if (act_ff[c].test[PN_SHORT_RST_BIT]) nxt_pns[c] = PNS_SEED;
        end
    end

    // Datapath flops
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            cnt_ff <= 3'h0;
            strobe_ff <= 1'b0;
            for (int c = 0; c < 2; c++) begin
                pnl_ff[c] <= PNL_SEED;
                pns_ff[c] <= PNS_SEED;
                walk_ff[c] <= P_WALK;
                data_ff[c] <= P_NEG;
            end
            tog_ff <= 2'h0;
            pd_ff <= 2'h0;
            sb_ff <= 2'h0;
            drst_ff <= 1'b0;
        end else if (I_CE) begin
            cnt_ff <= nxt_cnt;
            strobe_ff <= nxt_strobe;
            pnl_ff <= nxt_pnl;
            pns_ff <= nxt_pns;
            walk_ff <= nxt_walk;
            data_ff <= nxt_data;
            tog_ff <= nxt_tog;
            pd_ff <= nxt_pd;
            sb_ff <= nxt_sb;
            drst_ff <= nxt_drst;
        end
    end

    // Outputs straight from flops
    assign O_REG_RDATA = rdata_ff;
    assign O_REG_RVALID = rvalid_ff;
    assign O_SAMPLE_STROBE = strobe_ff;
    assign O_DATA_A = data_ff[0];
    assign O_DATA_B = data_ff[1];
    assign O_PWRDN = pd_ff;
    assign O_STANDBY = sb_ff;
    assign O_DIG_RESET = drst_ff;
    assign O_DCS_EN = gact_ff.clkcfg[DCS_BIT];
    assign O_SELF_TEST_EN = gact_ff.self_test[SELF_TEST_EN_BIT];
    assign O_SELF_TEST_INIT = gact_ff.self_test[SELF_TEST_INIT_BIT];

    // ======================================================
    // Assertions
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESETN);

    AST_DIV_STROBE: assert property (I_CE && hit |=> O_SAMPLE_STROBE)
        else $error("Divider end did not strobe");
    AST_DIV_RANGE: assert property (cnt_ff <= DIV_MAX)
        else $error("Divider count beyond divide by six");
    AST_PWRDN: assert property (I_CE && act_ff[0].modes[1:0] == MD_PWRDN
        |=> O_PWRDN[0] && !O_STANDBY[0])
        else $error("Power-down mode not decoded");
    AST_DRST: assert property (I_CE && act_ff[1].modes[1:0] == MD_DRST |=> O_DIG_RESET)
        else $error("Digital reset mode not decoded");
    AST_MIDSCALE: assert property (I_CE && hit && act_ff[0].test[3:0] == TM_MID
        |=> O_DATA_A == P_MID)
        else $error("Midscale pattern missing");
    AST_PNS: assert property (I_CE && hit && act_ff[1].test[3:0] == TM_PNS
        |=> O_DATA_B[8:0] == $past(pns_ff[1]))
        else $error("Short random pattern missing");
    AST_WORD: assert property (I_CE && hit && act_ff[0].test[3:0] == TM_WORD
        |=> O_DATA_A == ($past(tog_ff[0]) ? P_POS : P_NEG))
        else $error("Word toggle pattern wrong");
    AST_SHADOW: assert property (!commit_ff |=> $stable(act_ff[0]) && $stable(gact_ff))
        else $error("Active settings moved without commit");
    AST_COMMIT: assert property (I_CE && I_REG_WR && I_REG_ADDR == A_COMMIT
        && I_REG_WDATA == 8'h01 ##1 I_CE && !I_REG_WR |=> !commit_ff
        && act_ff[0] == $past(shd_ff[0]))
        else $error("Commit did not load or self-clear");
    AST_SEL_A: assert property (I_CE && I_REG_WR && local_hit && sel_ff == 8'h01
        |=> $stable(shd_ff[1]))
        else $error("Unselected channel was written");
    AST_READ_A: assert property (I_CE && I_REG_RD && I_REG_ADDR == A_TEST
        && sel_ff == 8'h03 |=> O_REG_RVALID && O_REG_RDATA == $past(shd_ff[0].test))
        else $error("Dual-select read did not return channel A");
    AST_PASS: assert property (I_CE && hit && act_ff[1].test[3:0] == TM_OFF
        |=> O_DATA_B == $past(I_SAMPLE_B))
        else $error("Sample data not passed through");

    COV_COMMIT: cover property (commit_ff ##1 !commit_ff);
    COV_PNL: cover property (O_SAMPLE_STROBE && act_ff[0].test[3:0] == TM_PNL);
    COV_DIV6: cover property (hit && div_eff == DIV_MAX);
endmodule : acmtc_regs

// File: verification/acmtc_host.sv
// Host-side parallel register port master model issuing register cycles
`timescale 1ns/1ps
module acmtc_host
    import acmtc_pkg::*;
(
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    // ======================================================
    // Idle levels at time zero
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    // One write pulse; released lines show the inverse so stale data never looks valid
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask : wr_reg
    // Read pulse; the answer must stand in the very next cycle
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
        d = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
    endtask : rd_reg
    // Steer later local accesses to the chosen channels
    task automatic select(input logic [1:0] s);
        wr_reg(A_CHSEL, {6'h00, s});
    endtask : select
    // All shadowed settings go live together only through this write
    task automatic commit();
        wr_reg(A_COMMIT, 8'h01);
    endtask : commit
endmodule : acmtc_host

// File: verification/tb_acmtc_regs.sv
// Self-checking bench for the mode, divider and test pattern register bank
`timescale 1ns/1ps
module tb_acmtc_regs
    import acmtc_pkg::*;
;
    localparam logic [15:0] USER = 16'h1234;
    logic ref_clk = 1'b0, resetn = 1'b0, ce = 1'b1, rvalid, strobe, dig_reset;
    logic wr, rd, dcs_en, st_en, st_init;
    logic [7:0] addr, wdata, rdata, d;
    logic [15:0] samp_a = 16'h1357, samp_b = 16'h2468, data_a, data_b, prev;
    logic [1:0] pwrdn, standby;
    int num_errors = 0, comparisons = 0, n;
    logic [7:0] ra [8] = '{A_CHSEL, A_MODES, A_CLKCFG, A_CLKDIV, A_TEST, A_SELF_TEST,
        A_COMMIT, 8'h42};
    logic [7:0] rv [8] = '{R_CHSEL, R_MODES, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] tc [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0A, 8'h08, 8'h16, 8'h25};
    logic [15:0] tv [8] = '{16'h1357, P_MID, P_POS, P_NEG, P_SYNC, USER, 16'h01FF, 16'hFFFF};
    // Toggling and walking codes, with the change expected between two strobes
    logic [7:0] gc [5] = '{8'h04, 8'h07, 8'h09, 8'h0C, 8'h0B};
    logic [15:0] gx [4] = '{16'hFFFF, 16'hFFFF, P_CHK_A, 16'hFFFF};
    // ======================================================
    // Clock, design and host model
    always #5 ref_clk = ~ref_clk;
    acmtc_regs #(.USER_PATTERN(USER)) DUT (.I_REF_CLK(ref_clk), .I_RESETN(resetn), .I_CE(ce),
        .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
        .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .I_SAMPLE_A(samp_a), .I_SAMPLE_B(samp_b),
        .O_SAMPLE_STROBE(strobe), .O_DATA_A(data_a), .O_DATA_B(data_b), .O_PWRDN(pwrdn),
        .O_STANDBY(standby), .O_DIG_RESET(dig_reset), .O_DCS_EN(dcs_en),
        .O_SELF_TEST_EN(st_en), .O_SELF_TEST_INIT(st_init));
    acmtc_host HOST (.i_clk(ref_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_wr(wr),
        .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
    // ======================================================
    // Comparison and helpers
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Bounded wait for the next divided-clock pulse
    task automatic wait_strobe();
        for (n = 0; n < 16; n++) begin
            @(posedge ref_clk);
            #1;
            if (strobe === 1'b1) break;
        end
        check({15'h0000, strobe}, 16'h0001);
    endtask : wait_strobe
    // Settings go live a few cycles after the commit write
    task automatic go_live();
        HOST.commit();
        repeat (4) @(posedge ref_clk);
        #1;
    endtask : go_live
    // ======================================================
    // Scenarios
    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            HOST.rd_reg(ra[i], d);
            check({8'h00, d}, {8'h00, rv[i]});
        end
    endtask : t_reset
    // Modes stay shadowed until commit; channel steering; globals ignore steering
    task automatic t_modes();
        HOST.select(2'h1);
        HOST.wr_reg(A_MODES, 8'h01);
        repeat (4) @(posedge ref_clk);
        #1;
        check({14'h0000, pwrdn}, 16'h0000);
        go_live();
        check({14'h0000, pwrdn}, 16'h0001);
        HOST.select(2'h3);
        HOST.wr_reg(A_MODES, 8'h02);
        go_live();
        check({12'h000, standby, pwrdn}, 16'h000C);
        HOST.wr_reg(A_MODES, 8'h03);
        go_live();
        check({15'h0000, dig_reset}, 16'h0001);
        HOST.wr_reg(A_MODES, 8'h00);
        HOST.select(2'h2);
        HOST.wr_reg(A_CLKCFG, 8'h01);
        HOST.wr_reg(A_SELF_TEST, 8'h05);
        go_live();
        check({11'h000, dig_reset, dcs_en, st_en, st_init, standby[1]}, 16'h000E);
        HOST.rd_reg(A_COMMIT, d);
        check({8'h00, d}, 16'h0000);
    endtask : t_modes
    // Local reads with both channels selected answer with channel A
    task automatic t_readsel();
        HOST.select(2'h1);
        HOST.wr_reg(A_TEST, 8'h01);
        HOST.select(2'h2);
        HOST.wr_reg(A_TEST, 8'h02);
        HOST.rd_reg(A_TEST, d);
        check({8'h00, d}, 16'h0002);
        HOST.select(2'h3);
        HOST.rd_reg(A_TEST, d);
        check({8'h00, d}, 16'h0001);
        HOST.wr_reg(A_TEST, 8'h00);
    endtask : t_readsel
    // Strobe period equals divider code plus one for every valid code
    task automatic t_div();
        for (int k = 5; k >= 0; k--) begin
            HOST.wr_reg(A_CLKDIV, k[7:0]);
            go_live();
            wait_strobe();
            wait_strobe();
            n = 0;
            do begin
                @(posedge ref_clk);
                #1;
                n++;
            end while (strobe !== 1'b1 && n < 16);
            check(n[15:0], 16'(k + 1));
        end
    endtask : t_div
    // Each code sets channel A data (code 00 passes its samples) while channel B keeps its samples
    task automatic t_pattern();
        HOST.select(2'h1);
        for (int i = 0; i < 8; i++) begin
            HOST.wr_reg(A_TEST, tc[i]);
            go_live();
            wait_strobe();
            wait_strobe();
            check(data_a, tv[i]);
            check(data_b, samp_b);
        end
        // Toggles flip by a known mask per strobe; one-bit-high walks left
        for (int i = 0; i < 5; i++) begin
            HOST.wr_reg(A_TEST, gc[i]);
            go_live();
            prev = data_a;
            wait_strobe();
            if (i < 4) begin
                check(data_a ^ prev, gx[i]);
            end else begin
                check(data_a, {prev[14:0], prev[15]});
            end
        end
        HOST.select(2'h3);
        HOST.wr_reg(A_TEST, 8'h02);
        go_live();
        wait_strobe();
        check(data_b & data_a, P_POS);
        // Short sequence on channel B steps by its feedback taps
        HOST.wr_reg(A_TEST, 8'h06);
        go_live();
        prev = data_b;
        wait_strobe();
        check(data_b, {7'h00, prev[7:0], prev[8] ^ prev[4]});
    endtask : t_pattern
    // Live samples pass; a low clock enable freezes data and refuses writes
    task automatic t_ce();
        HOST.select(2'h3);
        HOST.wr_reg(A_TEST, 8'h00);
        go_live();
        @(posedge ref_clk);
        samp_a <= 16'hA5C3;
        samp_b <= 16'h3C5A;
        wait_strobe();
        wait_strobe();
        check(data_a, 16'hA5C3);
        check(data_b, 16'h3C5A);
        @(posedge ref_clk);
        ce <= 1'b0;
        samp_a <= 16'h0F0F;
        HOST.wr_reg(A_CHSEL, 8'h01);
        repeat (2) @(posedge ref_clk);
        #1;
        check(data_a, 16'hA5C3);
        @(posedge ref_clk);
        ce <= 1'b1;
        HOST.rd_reg(A_CHSEL, d);
        check({8'h00, d}, {8'h00, R_CHSEL});
        check(data_a, 16'h0F0F);
    endtask : t_ce
    // ======================================================
    // Verdict and main sequence
    task automatic finish_test();
        $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset();
        t_modes();
        t_readsel();
        t_div();
        t_pattern();
        t_ce();
        finish_test();
    end
    // Watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (50000) @(posedge ref_clk);
        num_errors++;
        finish_test();
    end
endmodule : tb_acmtc_regs
